/* File: dic_dev.sv */
// dma interrupt configuration, status/id and request logic of the module
`timescale 1ns/1ps
module dic_dev (
  input wire logic core_clk,
  input wire logic nrst,
  dic_link_if.dev link,
  input wire logic [1:0] dma_done,
  input wire logic dma_done_clr,
  input wire logic [7:0] logical_addr,
  output logic irq_condition_flag,
  output logic irq_asserting
);
  import dic_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic byte_status_select_r;
  logic status_from_logical_addr_r;
  logic rsv13_r;
  logic rsv11_r;
  logic [2:0] irq_level_sel_r;
  logic flag_r;
  logic enable_r;
  logic [4:0] status_byte_r;
  logic acked_r;
  logic reg_ack_r;
  logic [15:0] reg_rdata_r;
  logic iack_ack_r;
  logic [15:0] iack_data_r;
  logic [7:1] irq_oe_r;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire take = link.reg_req & ~reg_ack_r;
  wire hit_cfg = link.reg_addr == DIC_OFS_CONFIG;
  wire hit_en = link.reg_addr == DIC_OFS_ENABLE;
  wire hit_sb = link.reg_addr == DIC_OFS_SBYTE;
  wire wr_hi = take & link.reg_wr & link.reg_be[1];
  wire wr_lo = take & link.reg_wr & link.reg_be[0];
  wire [15:0] wd = link.reg_wdata;
  // reserved positions other than bits 13 and 11 read back as zero; software must not rely on it
  wire [15:0] cfg_view = {byte_status_select_r, status_from_logical_addr_r, rsv13_r, 1'b0,
                          rsv11_r, 3'h0, flag_r, 4'h0, irq_level_sel_r};
  wire [15:0] en_view = {4'h0, enable_r, 11'h000};
  wire [15:0] sb_view = {8'h00, status_byte_r, DIC_SBYTE_LOW};
  wire [15:0] rd_mux = hit_cfg ? cfg_view : hit_en ? en_view : hit_sb ? sb_view : 16'h0000;
  // the enable bit only moves when the confirm bit is written as one
  wire en_write = wr_hi & hit_en & wd[DIC_EN_CONFIRM];

  // ----------------------------------------------------------------
  // acknowledge decode
  // ----------------------------------------------------------------
  wire [7:0] status_hi = {status_byte_r, DIC_SBYTE_LOW};
  wire width_ok = byte_status_select_r | (link.iack_width != DIC_W8);
  wire iack_hit = link.iack_req & ~iack_ack_r & (link.iack_level == irq_level_sel_r)
                  & irq_asserting & width_ok;
  // byte mode picks one source, word mode concatenates both
  wire [7:0] byte_sid = status_from_logical_addr_r ? logical_addr : status_hi;
  wire [15:0] sid = byte_status_select_r ? {8'h00, byte_sid} : {status_hi, logical_addr};

  // ----------------------------------------------------------------
  // request line
  // ----------------------------------------------------------------
  // bits 13 and 11 must be set by software; without them the request stays off
  wire cfg_ready = rsv13_r & rsv11_r & (irq_level_sel_r != 3'h0);
  assign irq_asserting = flag_r & enable_r & cfg_ready & ~acked_r;
  assign irq_condition_flag = flag_r;

  // one-hot decode of the level onto lines 1..7
  function automatic logic [7:1] level_lines(input logic [2:0] lvl);
    logic [7:0] v;
    v = 8'h01 << lvl;
    return v[7:1];
  endfunction

  // ----------------------------------------------------------------
  // configuration register, hard reset only
  // ----------------------------------------------------------------
  // nrst is the hard reset; a soft reset never reaches these flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byte_status_select_r <= DIC_CFG_RESET[DIC_CFG_BYTE_SEL];
      status_from_logical_addr_r <= DIC_CFG_RESET[DIC_CFG_LA_SEL];
      rsv13_r <= DIC_CFG_RESET[DIC_CFG_RSV13];
      rsv11_r <= DIC_CFG_RESET[DIC_CFG_RSV11];
      irq_level_sel_r <= DIC_CFG_RESET[2:0];
    end else begin
      if (wr_hi && hit_cfg) begin
        byte_status_select_r <= wd[DIC_CFG_BYTE_SEL];
        status_from_logical_addr_r <= wd[DIC_CFG_LA_SEL];
        rsv13_r <= wd[DIC_CFG_RSV13];
        rsv11_r <= wd[DIC_CFG_RSV11];
      end
      if (wr_lo && hit_cfg) begin
        irq_level_sel_r <= wd[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // enable and status byte registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enable_r <= 1'b0;
      status_byte_r <= DIC_SBYTE_RESET;
    end else begin
      if (en_write) begin
        enable_r <= wd[DIC_EN_ENABLE];
      end
      if (wr_lo && hit_sb) begin
        status_byte_r <= wd[7:3];
      end
    end
  end

  // ----------------------------------------------------------------
  // shared condition flag
  // ----------------------------------------------------------------
  // either controller sets it; a set in the clear cycle wins so no event is lost
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else if (|dma_done) begin
      flag_r <= 1'b1;
    end else if (dma_done_clr) begin
      flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // acknowledge: release the line, keep the flag
  // ----------------------------------------------------------------
  // acked holds the line off until software disables, which is the first re-arm step
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acked_r <= 1'b0;
    end else if (iack_hit) begin
      acked_r <= 1'b1;
    end else if (!enable_r) begin
      acked_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_ack_r <= 1'b0;
      reg_rdata_r <= 16'h0000;
      iack_ack_r <= 1'b0;
      iack_data_r <= 16'h0000;
      irq_oe_r <= 7'h00;
    end else begin
      reg_ack_r <= take;
      if (take) begin
        reg_rdata_r <= rd_mux;
      end
      iack_ack_r <= iack_hit;
      if (iack_hit) begin
        iack_data_r <= sid;
      end
      // registered so the wire never glitches during a level change
      irq_oe_r <= irq_asserting ? level_lines(irq_level_sel_r) : 7'h00;
    end
  end

  assign link.reg_ack = reg_ack_r;
  assign link.reg_rdata = reg_rdata_r;
  assign link.iack_ack = iack_ack_r;
  assign link.iack_data = iack_data_r;
  assign link.irq_oe = irq_oe_r;
  assign link.irq_out = 7'h00; // open drain: only ever pulls low
endmodule

/* File: dic_hdl.sv */
// backplane interrupt handler: register accesses and acknowledge cycles under avalon-mm control
`timescale 1ns/1ps
module dic_hdl #(
  parameter int IACK_TIMEOUT = dic_pkg::DIC_IACK_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  dic_link_if.hdl link,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  import dic_pkg::*;

  typedef enum {DIC_IDLE, DIC_REG, DIC_ACK} dic_state_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dic_state_t state_r;
  logic wait_done_r;
  logic [31:0] rdata_r;
  logic [11:0] addr_r;
  logic wr_r;
  logic [1:0] be_r;
  logic [15:0] wdata_r;
  logic [15:0] result_r;
  logic [2:0] ack_level_r;
  dic_width_t ack_width_r;
  logic [2:0] event_r;
  logic [2:0] mask_r;
  logic [15:0] tmo_r;
  logic irq_any_d_r;

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  wire access = avs_read | avs_write;
  assign avs_waitrequest = access & ~wait_done_r;
  wire wr_now = avs_write & wait_done_r;
  wire [7:1] irq_act = ~link.irq_n;
  wire busy = state_r != DIC_IDLE;
  wire go_reg = wr_now & (avs_address == DIC_H_CMD) & avs_writedata[0] & ~busy;
  wire go_ack = wr_now & (avs_address == DIC_H_CMD) & avs_writedata[1] & ~busy & ~go_reg;
  wire tmo_hit = (state_r == DIC_ACK) & ~link.iack_ack & (tmo_r == 16'(IACK_TIMEOUT - 1));
  wire done_evt = ((state_r == DIC_REG) & link.reg_ack) | ((state_r == DIC_ACK) & link.iack_ack);
  wire irq_evt = (|irq_act) & ~irq_any_d_r;
  wire [2:0] ev_set = {irq_evt, tmo_hit, done_evt};
  wire [31:0] rd_mux =
    (avs_address == DIC_H_ACC) ? {13'h0, be_r, wr_r, 4'h0, addr_r} :
    (avs_address == DIC_H_WDATA) ? {16'h0, wdata_r} :
    (avs_address == DIC_H_RESULT) ? {16'h0, result_r} :
    (avs_address == DIC_H_STATUS) ? {16'h0, irq_act, 9'(busy)} :
    (avs_address == DIC_H_EVENT) ? {29'h0, event_r} :
    (avs_address == DIC_H_MASK) ? {29'h0, mask_r} :
    (avs_address == DIC_H_IACK) ? {26'h0, ack_width_r, 1'b0, ack_level_r} : 32'h0;
  assign avs_readdata = rdata_r;
  assign irq = |(event_r & mask_r);

  // settings and read data
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_done_r <= 1'b0;
      rdata_r <= 32'h0;
      addr_r <= 12'h000;
      wr_r <= 1'b0;
      be_r <= 2'h3;
      wdata_r <= 16'h0000;
      mask_r <= 3'h0;
      ack_level_r <= 3'h1;
      ack_width_r <= DIC_W16;
    end else begin
      wait_done_r <= access & ~wait_done_r;
      if (access && !wait_done_r) begin
        rdata_r <= rd_mux;
      end
      if (wr_now && avs_address == DIC_H_ACC) begin
        addr_r <= avs_writedata[11:0];
        wr_r <= avs_writedata[16];
        be_r <= avs_writedata[18:17];
      end
      if (wr_now && avs_address == DIC_H_WDATA) begin
        wdata_r <= avs_writedata[15:0];
      end
      if (wr_now && avs_address == DIC_H_MASK) begin
        mask_r <= avs_writedata[2:0];
      end
      if (wr_now && avs_address == DIC_H_IACK) begin
        ack_level_r <= avs_writedata[2:0];
        ack_width_r <= (avs_writedata[5:4] == 2'h3) ? DIC_W32 : dic_width_t'(avs_writedata[5:4]);
      end
    end
  end

  // sticky events: write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      event_r <= 3'h0;
      irq_any_d_r <= 1'b0;
    end else begin
      irq_any_d_r <= |irq_act;
      if (wr_now && avs_address == DIC_H_EVENT) begin
        event_r <= (event_r & ~avs_writedata[2:0]) | ev_set;
      end else begin
        event_r <= event_r | ev_set;
      end
    end
  end

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  // the device stays silent on acknowledges it does not own, so a timeout ends the wait
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= DIC_IDLE;
      tmo_r <= 16'h0000;
      result_r <= 16'h0000;
    end else begin
      unique case (state_r)
        DIC_IDLE: begin
          tmo_r <= 16'h0000;
          if (go_reg) begin
            state_r <= DIC_REG;
          end else if (go_ack) begin
            state_r <= DIC_ACK;
          end
        end
        DIC_REG: begin
          if (link.reg_ack) begin
            result_r <= link.reg_rdata;
            state_r <= DIC_IDLE;
          end
        end
        DIC_ACK: begin
          tmo_r <= tmo_r + 16'h0001;
          if (link.iack_ack) begin
            result_r <= link.iack_data;
            state_r <= DIC_IDLE;
          end else if (tmo_hit) begin
            state_r <= DIC_IDLE;
          end
        end
      endcase
    end
  end

  assign link.reg_req = state_r == DIC_REG;
  assign link.reg_wr = wr_r;
  assign link.reg_addr = addr_r;
  assign link.reg_be = be_r;
  assign link.reg_wdata = wdata_r;
  assign link.iack_req = state_r == DIC_ACK;
  assign link.iack_level = ack_level_r;
  assign link.iack_width = ack_width_r;
endmodule

/* File: dic_link_if.sv */
// link between the dma interrupt logic and the backplane interrupt handler
`timescale 1ns/1ps
interface dic_link_if;
  import dic_pkg::*;
  // register access into the module's a24/a32 space
  logic reg_req;
  logic reg_wr;
  logic [11:0] reg_addr;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata;
  logic reg_ack;
  logic [15:0] reg_rdata;
  // interrupt request lines 1..7, open drain, low active on the wire
  logic [7:1] irq_out;
  logic [7:1] irq_oe;
  logic [7:1] irq_n;
  // acknowledge cycle
  logic iack_req;
  logic [2:0] iack_level;
  dic_width_t iack_width;
  logic iack_ack;
  logic [15:0] iack_data;
  // wired level: low while any driver pulls low
  assign irq_n = ~(irq_oe & ~irq_out);
  modport dev (
    input reg_req, reg_wr, reg_addr, reg_be, reg_wdata, iack_req, iack_level, iack_width,
    output reg_ack, reg_rdata, irq_out, irq_oe, iack_ack, iack_data
  );
  modport hdl (
    output reg_req, reg_wr, reg_addr, reg_be, reg_wdata, iack_req, iack_level, iack_width,
    input reg_ack, reg_rdata, irq_n, iack_ack, iack_data
  );
endinterface

/* File: dic_link_sva.sv */
// checker on the link between the dma interrupt logic and its handler
`timescale 1ns/1ps
module dic_link_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_req,
  input wire logic reg_ack,
  input wire logic [7:1] irq_out,
  input wire logic [7:1] irq_oe,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire dic_pkg::dic_width_t iack_width,
  input wire logic iack_ack,
  input wire logic [15:0] iack_data
);
  import dic_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // handshakes and request lines
  // ----------------------------------------------------------------
  sequence s_reg_pulse; reg_ack ##1 !reg_ack; endsequence
  // four quiet cycles: re-arm needs several bus accesses, so none comes sooner
  sequence s_line_off; (irq_oe == 7'h00) [*4]; endsequence
  property p_reg_ack; $rose(reg_req) |=> s_reg_pulse; endproperty
  property p_ack_cause;
    iack_ack |-> $past(iack_req) && ({$past(irq_oe), 1'b0} == (8'h01 << $past(iack_level)));
  endproperty
  property p_byte_upper; iack_ack && iack_width == DIC_W8 |-> iack_data[15:8] == 8'h00; endproperty
  property p_word_upper; iack_ack && iack_data[15:8] != 8'h00 |-> iack_data[10:8] == 3'h3; endproperty
  property p_release; iack_ack |=> s_line_off; endproperty
  property p_one_line; $onehot0(irq_oe); endproperty
  property p_pull_low; irq_out == 7'h00; endproperty
  property p_ack_pulse; iack_ack |=> !iack_ack; endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("register ack late");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without line");
  a_byte_upper: assert property (p_byte_upper) else $error("byte ack upper");
  a_word_upper: assert property (p_word_upper) else $error("word id low bits");
  a_release: assert property (p_release) else $error("line kept");
  a_one_line: assert property (p_one_line) else $error("two lines");
  a_pull_low: assert property (p_pull_low) else $error("line driven high");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
endmodule

/* File: dic_pkg.sv */
// shared constants for the dma interrupt configuration block and its interrupt handler
// How it works
// - byte status mode answers any acknowledge width
// - word mode answers 16 and 32 bit acknowledges
// - word mode: status byte high, address low
// - word mode ignores byte wide acknowledges
// - byte mode: address or status byte by select
// - software keeps address select clear in word mode
// - config bits cleared by hard reset only
// - software sets bits 13 and 11 first
// - reserved bits written zero, reads meaningless
// - condition flag sticky until software re-arms
// - acknowledge releases request, flag stays
// - request line number equals level field
// - software programs level one through seven
// - both dma controllers share one condition
// - config register at offset 8, 16/8 bit
// - interrupt reaches bus only when enabled
// - re-arm: disable, clear done, enable
package dic_pkg;
  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [11:0] DIC_OFS_CONFIG = 12'h008;
  localparam logic [11:0] DIC_OFS_ENABLE = 12'h012;
  localparam logic [11:0] DIC_OFS_SBYTE = 12'h020;
  localparam int DIC_CFG_BYTE_SEL = 15;
  localparam int DIC_CFG_LA_SEL = 14;
  localparam int DIC_CFG_RSV13 = 13;
  localparam int DIC_CFG_RSV11 = 11;
  localparam int DIC_CFG_FLAG = 7;
  localparam int DIC_EN_CONFIRM = 11;
  localparam int DIC_EN_ENABLE = 8;
  localparam logic [15:0] DIC_CFG_RESET = 16'h0000;
  localparam logic [2:0] DIC_SBYTE_LOW = 3'h3;
  localparam logic [4:0] DIC_SBYTE_RESET = 5'h00;
  // acknowledge widths
  typedef enum logic [1:0] {DIC_W8, DIC_W16, DIC_W32} dic_width_t;
  // ----------------------------------------------------------------
  // handler register map (avalon-mm byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] DIC_H_CMD = 5'h00;
  localparam logic [4:0] DIC_H_ACC = 5'h04;
  localparam logic [4:0] DIC_H_WDATA = 5'h08;
  localparam logic [4:0] DIC_H_RESULT = 5'h0c;
  localparam logic [4:0] DIC_H_STATUS = 5'h10;
  localparam logic [4:0] DIC_H_EVENT = 5'h14;
  localparam logic [4:0] DIC_H_MASK = 5'h18;
  localparam logic [4:0] DIC_H_IACK = 5'h1c;
  localparam int DIC_EV_DONE = 0;
  localparam int DIC_EV_TIMEOUT = 1;
  localparam int DIC_EV_IRQ = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DIC_CLK_MHZ = 250;
  localparam int DIC_IACK_TIMEOUT_NS = 1000;
  localparam int DIC_IACK_TIMEOUT_CYC = DIC_IACK_TIMEOUT_NS * DIC_CLK_MHZ / 1000;
endpackage

/* File: dma_irq_config_status_id_bench.sv */
// self-checking bench for the dma interrupt logic joined to its handler
`timescale 1ns/1ps
module dma_irq_config_status_id_bench;
  import dic_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [1:0] dma_done = 2'h0;
  logic dma_done_clr = 1'b0;
  logic [7:0] logical_addr = 8'h00;
  logic irq_condition_flag;
  logic irq_asserting;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] t;
  logic [15:0] q;
  logic [15:0] v;
  logic [2:0] ev;
  dic_link_if link();
  dic_dev u_dic_dev (.core_clk(core_clk), .nrst(nrst), .link(link), .dma_done(dma_done),
    .dma_done_clr(dma_done_clr), .logical_addr(logical_addr),
    .irq_condition_flag(irq_condition_flag), .irq_asserting(irq_asserting));
  dic_hdl #(.IACK_TIMEOUT(16)) u_dic_hdl (.core_clk(core_clk), .nrst(nrst), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  dic_link_sva u_dic_link_sva (.core_clk(core_clk), .nrst(nrst), .reg_req(link.reg_req),
    .reg_ack(link.reg_ack), .irq_out(link.irq_out), .irq_oe(link.irq_oe),
    .iack_req(link.iack_req), .iack_level(link.iack_level), .iack_width(link.iack_width),
    .iack_ack(link.iack_ack), .iack_data(link.iack_data));
  // 250 mhz clock and a hang guard well above the expected run
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic bsy();
    logic [31:0] r;
    r = 32'h1;
    while (r[0] !== 1'b0) av(1'b0, DIC_H_STATUS, 32'h0, r);
  endtask
  task automatic lk(input logic w, input logic [11:0] a, input logic [1:0] be,
    input logic [15:0] d);
    logic [31:0] r;
    av(1'b1, DIC_H_ACC, {13'h0, be, w, 4'h0, a}, r);
    av(1'b1, DIC_H_WDATA, {16'h0, d}, r);
    av(1'b1, DIC_H_CMD, 32'h1, r);
    bsy();
    av(1'b0, DIC_H_RESULT, 32'h0, r);
    q = r[15:0];
  endtask
  task automatic ia(input logic [2:0] lv, input logic [1:0] w);
    logic [31:0] r;
    av(1'b1, DIC_H_IACK, {26'h0, w, 1'b0, lv}, r);
    av(1'b1, DIC_H_CMD, 32'h2, r);
    bsy();
    av(1'b0, DIC_H_RESULT, 32'h0, r);
    q = r[15:0];
    av(1'b0, DIC_H_EVENT, 32'h0, r);
    ev = r[2:0];
    av(1'b1, DIC_H_EVENT, 32'h7, r);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic idle_chk();
    lk(1'b0, DIC_OFS_CONFIG, 2'h3, 16'h0);
    chk("config reset", 16'h0000, q);
    lk(1'b0, DIC_OFS_ENABLE, 2'h3, 16'h0);
    chk("enable reset", 16'h0000, q);
    lk(1'b0, DIC_OFS_SBYTE, 2'h3, 16'h0);
    chk("sbyte reset", 16'h0003, q);
    lk(1'b0, 12'h00a, 2'h3, 16'h0);
    chk("unmapped", 16'h0000, q);
    av(1'b0, 5'h1e, 32'h0, t);
    chk("handler unmapped", 32'h0, t);
    chk("irq idle", 1'b0, irq);
  endtask
  task automatic run(input logic [2:0] lv, input int md, input logic [1:0] w);
    logic [15:0] c;
    logic [4:0] s;
    logic [15:0] e;
    logic [6:0] ln;
    logic [6:0] ln_n;
    c = {md != 0, md == 1, 3'h5, 8'h00, lv};
    s = $urandom;
    ln = 7'h01 << (lv - 3'h1);
    ln_n = ~ln;
    logical_addr <= $urandom;
    lk(1'b1, DIC_OFS_CONFIG, 2'h3, c);
    lk(1'b1, DIC_OFS_SBYTE, 2'h1, {8'h00, s, 3'h0});
    lk(1'b1, DIC_OFS_ENABLE, 2'h3, 16'h0900);
    chk("no line yet", 7'h7f, link.irq_n);
    // either controller raises the one shared condition
    @(posedge core_clk);
    dma_done[lv[0]] <= 1'b1;
    @(posedge core_clk);
    dma_done <= 2'h0;
    av(1'b0, DIC_H_STATUS, 32'h0, t);
    chk("active line", ln, t[15:9]);
    @(negedge core_clk);
    chk("wired line", ln_n, link.irq_n);
    chk("flag set", 1'b1, irq_condition_flag);
    chk("line request", 1'b1, irq_asserting);
    av(1'b0, DIC_H_EVENT, 32'h0, t);
    chk("line event", 1'b1, t[DIC_EV_IRQ]);
    chk("irq masked", 1'b0, irq);
    av(1'b1, DIC_H_MASK, 32'h4, t);
    @(negedge core_clk);
    chk("irq unmasked", 1'b1, irq);
    av(1'b1, DIC_H_EVENT, 32'h7, t);
    @(negedge core_clk);
    chk("irq cleared", 1'b0, irq);
    av(1'b1, DIC_H_MASK, 32'h0, t);
    if (md == 0) begin
      ia(lv, 2'h0);
      chk("byte ack refused", 1'b1, ev[DIC_EV_TIMEOUT]);
    end
    ia((lv == 3'h7) ? 3'h1 : lv + 3'h1, w);
    chk("level refused", 1'b1, ev[DIC_EV_TIMEOUT]);
    ia(lv, w);
    e = (md == 0) ? {s, 3'h3, logical_addr} : {8'h00, (md == 1) ? logical_addr : {s, 3'h3}};
    chk("ack taken", 2'h1, ev[1:0]);
    chk("status id", e, q);
    chk("line released", 7'h7f, link.irq_n);
    chk("flag kept", 1'b1, irq_condition_flag);
    chk("request dropped", 1'b0, irq_asserting);
    lk(1'b0, DIC_OFS_CONFIG, 2'h3, 16'h0);
    chk("config flag", c | 16'h0080, q & 16'he887);
    lk(1'b1, DIC_OFS_ENABLE, 2'h3, 16'h0100);
    lk(1'b0, DIC_OFS_ENABLE, 2'h3, 16'h0);
    chk("unconfirmed kept", 16'h0800, q & 16'h0900);
    lk(1'b1, DIC_OFS_ENABLE, 2'h3, 16'h0800);
    lk(1'b0, DIC_OFS_ENABLE, 2'h3, 16'h0);
    chk("disabled", 16'h0000, q & 16'h0900);
    @(posedge core_clk);
    dma_done_clr <= 1'b1;
    @(posedge core_clk);
    dma_done_clr <= 1'b0;
    lk(1'b0, DIC_OFS_CONFIG, 2'h3, 16'h0);
    chk("flag cleared", c, q & 16'he887);
    lk(1'b1, DIC_OFS_ENABLE, 2'h3, 16'h0900);
    chk("rearmed quiet", 7'h7f, link.irq_n);
  endtask
  initial begin
    void'($urandom(32'ha7a8d4f2));
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    idle_chk();
    $display("test reset done");
    // random configurations, then a high byte write that leaves the low byte
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      v = v & 16'he807;
      if (!v[15]) v[14] = 1'b0;
      lk(1'b1, DIC_OFS_CONFIG, 2'h3, v);
      lk(1'b0, DIC_OFS_CONFIG, 2'h3, 16'h0);
      chk("config rw", v, q & 16'he887);
      lk(1'b1, DIC_OFS_CONFIG, 2'h2, 16'h0000);
      lk(1'b0, DIC_OFS_CONFIG, 2'h3, 16'h0);
      chk("config byte", v & 16'h0007, q & 16'he887);
    end
    $display("test config done");
    for (int l = 1; l <= 7; l++) begin
      run(l[2:0], l % 3, (l % 3 == 0) ? {l[2], ~l[2]} : l[2:1]);
    end
    $display("test levels done");
    // hard reset in mid-run clears what was configured
    lk(1'b1, DIC_OFS_CONFIG, 2'h3, 16'he807);
    lk(1'b1, DIC_OFS_ENABLE, 2'h3, 16'h0900);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    idle_chk();
    $display("test second reset done");
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
endmodule
